// ===== logic/smartcard_irq_pkg.sv
// constants and types for the smart card fifo and interrupt registers
package smartcard_irq_pkg;
   // ------------------------------------------------------------
   // register indexes, byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [3:0] IDX_DATA  = 4'h0;
   localparam logic [3:0] IDX_IEN   = 4'h1;
   localparam logic [3:0] IDX_ID    = 4'h2;
   localparam logic [3:0] IDX_LSR   = 4'h5;
   localparam logic [3:0] IDX_PSRC  = 4'h6;
   localparam logic [3:0] IDX_COUNT = 4'h7;
   localparam logic [3:0] IDX_THR   = 4'h8;
   localparam logic [3:0] IDX_FCTL  = 4'h9;
   localparam logic [3:0] IDX_ISTAT = 4'ha;
   localparam logic [3:0] IDX_IMASK = 4'hb;
   // ------------------------------------------------------------
   // enable and fifo control bit positions and pending level codes
   // ------------------------------------------------------------
   localparam int EN_PROTO = 7;
   localparam int EN_LINE  = 2;
   localparam int EN_TX    = 1;
   localparam int EN_RX    = 0;
   localparam int FCTL_RST = 0;
   localparam logic [1:0] LVL_LINE  = 2'h3;
   localparam logic [1:0] LVL_RX    = 2'h2;
   localparam logic [1:0] LVL_TX    = 2'h1;
   localparam logic [1:0] LVL_PROTO = 2'h0;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] IEN_RST = 8'h00;
   localparam logic [7:0] THR_RST = 8'h01;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic guardTo;
      logic frame;
      logic parity;
      logic overrun;
   } lineErr_s;
   typedef struct packed {
      logic guardTo;
      logic underflow;
      logic frame;
      logic parity;
      logic overrun;
   } lineStatus_s;
   typedef enum logic [1:0] {
      SHOW_LIVE = 2'b01,
      SHOW_HELD = 2'b10
   } show_e;
endpackage

// ===== logic/smartcard_fifo_irq_registers.sv
// smart card data fifo, interrupt enable and identification registers
//
// Operation
// - buffer write pushes byte, counts message length
// - writes beyond fifo depth silently dropped
// - buffer read pops byte, decrements count
// - read when empty flags underflow, blocks receiver
// - enable bit 7 allows protocol/timer interrupt
// - enable bit 2 allows line error interrupt
// - enable bit 1 allows transmit finished interrupt
// - enable bit 0 allows data available interrupt
// - four priority levels, line status highest
// - identification freezes until re-enable or cause cleared
// - writing one re-enables even if set
// - id bit 7 protocol present, source read clears
// - id bit 3 shows timeout status, raises data available level
// - timeout blocks receiver, empty or reset clears
// - id bit 0 low pending, bits 2:1 level
// - line status code 11, cleared by reading status
// - transmit finished code 01, cleared by id read
`timescale 1ns/1ps
module smartcard_fifo_irq_registers
   import smartcard_irq_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        rxValid,
   input  wire logic [7:0]  rxByte,
   input  wire lineErr_s    lineErr,
   input  wire logic        timeoutEvt,
   input  wire logic        txFinished,
   input  wire logic [3:0]  protoEvt,
   input  wire logic        txPop,
   output logic      [7:0]  txData,
   output logic             txDataValid,
   output logic      [7:0]  msgLen,
   output logic             irq
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   // ------------------------------------------------------------
   // wishbone decode
   // ------------------------------------------------------------
   logic       access, wr, rd;
   logic [3:0] idx;
   logic [7:0] wByte;
   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr     = access & wb_we_i & wb_sel_i[0];
   assign rd     = access & ~wb_we_i;
   assign idx    = wb_adr_i[5:2];
   assign wByte  = wb_dat_i[7:0];

   logic wrData, rdData, wrIen, rdId, rdLsr, rdPsrc;
   logic wrThr, wrFctl, wrIstat, wrImask;
   assign wrData  = wr && idx == IDX_DATA;
   assign rdData  = rd && idx == IDX_DATA;
   assign wrIen   = wr && idx == IDX_IEN;
   assign rdId    = rd && idx == IDX_ID;
   assign rdLsr   = rd && idx == IDX_LSR;
   assign rdPsrc  = rd && idx == IDX_PSRC;
   assign wrThr   = wr && idx == IDX_THR;
   assign wrFctl  = wr && idx == IDX_FCTL;
   assign wrIstat = wr && idx == IDX_ISTAT;
   assign wrImask = wr && idx == IDX_IMASK;

   // ------------------------------------------------------------
   // shared fifo
   // ------------------------------------------------------------
   logic [7:0]    mem [DEPTH];
   logic [PW-1:0] wrPtr, rdPtr;
   logic [CW-1:0] count, lenCount;
   logic          full, empty, fifoReset, rxBlock, fifo_timeout_status;
   logic          cpuPush, rxPush, push, cpuPop, txPopOk, pop;
   logic [7:0]    pushByte;
   assign full      = count == CW'(DEPTH);
   assign empty     = count == '0;
   assign fifoReset = wrFctl & wByte[FCTL_RST];
   assign cpuPush   = wrData & ~full;
   assign rxPush    = rxValid & ~rxBlock & ~fifo_timeout_status & ~full & ~wrData;
   assign push      = cpuPush | rxPush;
   assign pushByte  = cpuPush ? wByte : rxByte;
   assign cpuPop    = rdData & ~empty;
   assign txPopOk   = txPop & ~empty & ~rdData;
   assign pop       = cpuPop | txPopOk;
   function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
      nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= pushByte;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else if (fifoReset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= nextPtr(wrPtr);
         end
         if (pop) begin
            rdPtr <= nextPtr(rdPtr);
         end
         count <= count + CW'(push) - CW'(pop);
      end
   end

   // message length follows accepted software writes only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lenCount <= '0;
         msgLen   <= 8'h00;
      end else if (fifoReset) begin
         lenCount <= '0;
         msgLen   <= 8'h00;
      end else if (cpuPush) begin
         lenCount <= lenCount + CW'(1);
         msgLen   <= 8'(lenCount + CW'(1));
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txData      <= 8'h00;
         txDataValid <= 1'b0;
      end else begin
         txDataValid <= txPopOk;
         if (txPopOk) begin
            txData <= mem[rdPtr];
         end
      end
   end

   // ------------------------------------------------------------
   // line status, receive block and fifo timeout
   // ------------------------------------------------------------
   lineStatus_s lsr;
   logic        underflowEvt;
   assign underflowEvt = rdData & empty;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lsr <= '0;
      end else begin
         lsr <= (rdLsr ? lineStatus_s'('0) : lsr)
              | lineStatus_s'({lineErr.guardTo, underflowEvt, lineErr.frame,
                               lineErr.parity, lineErr.overrun});
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rxBlock <= 1'b0;
      end else if (underflowEvt) begin
         rxBlock <= 1'b1;
      end else if (fifoReset) begin
         rxBlock <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo_timeout_status <= 1'b0;
      end else if (timeoutEvt && !empty) begin
         fifo_timeout_status <= 1'b1;
      end else if (fifoReset || empty) begin
         fifo_timeout_status <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // sources and enables
   // ------------------------------------------------------------
   logic [7:0] ien, thr;
   logic [3:0] protoSrc;
   logic       txDonePend, clrTx, rxRaw;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ien <= IEN_RST;
         thr <= THR_RST;
      end else begin
         if (wrIen) begin
            ien <= wByte;
         end
         if (wrThr) begin
            thr <= wByte;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         protoSrc <= 4'h0;
      end else begin
         protoSrc <= (rdPsrc ? 4'h0 : protoSrc) | protoEvt;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txDonePend <= 1'b0;
      end else if (txFinished) begin
         txDonePend <= 1'b1;
      end else if (clrTx) begin
         txDonePend <= 1'b0;
      end
   end

   // threshold zero never fires on level alone
   assign rxRaw = ((thr != 8'h00) && (8'(count) >= thr)) || (fifo_timeout_status && !empty);

   logic linePend, rxPend, txPend, protoPend;
   assign linePend  = ien[EN_LINE] & (|lsr);
   assign rxPend    = ien[EN_RX] & rxRaw;
   assign txPend    = ien[EN_TX] & txDonePend;
   assign protoPend = ien[EN_PROTO] & (|protoSrc);

   logic       liveNone;
   logic [1:0] liveLevel;
   always_comb begin
      liveNone  = 1'b0;
      liveLevel = LVL_PROTO;
      if (linePend) begin
         liveLevel = LVL_LINE;
      end else if (rxPend) begin
         liveLevel = LVL_RX;
      end else if (txPend) begin
         liveLevel = LVL_TX;
      end else if (!protoPend) begin
         liveNone = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // identification freeze
   // ------------------------------------------------------------
   show_e      showState;
   logic       shownNone, stillPend, reEnable;
   logic [1:0] shownLevel;

   always_comb begin
      unique case (shownLevel)
         LVL_LINE:  stillPend = linePend;
         LVL_RX:    stillPend = rxPend;
         LVL_TX:    stillPend = txPend;
         LVL_PROTO: stillPend = protoPend;
      endcase
   end

   assign reEnable = wrIen & (|wByte);
   assign clrTx    = rdId & ~shownNone & (shownLevel == LVL_TX);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         showState  <= SHOW_LIVE;
         shownNone  <= 1'b1;
         shownLevel <= LVL_PROTO;
      end else begin
         unique case (showState)
            SHOW_LIVE: begin
               shownNone  <= liveNone;
               shownLevel <= liveLevel;
               if (rdId && !shownNone) begin
                  showState <= SHOW_HELD;
               end
            end
            SHOW_HELD: begin
               if (reEnable || !stillPend) begin
                  showState  <= SHOW_LIVE;
                  shownNone  <= liveNone;
                  shownLevel <= liveLevel;
               end
            end
            default: showState <= SHOW_LIVE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // sticky event status, mask and interrupt output
   // ------------------------------------------------------------
   logic [3:0] istat, imask, rawNow, rawPrev;
   assign rawNow = {|protoSrc, txDonePend, rxRaw, |lsr};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         istat   <= 4'h0;
         imask   <= 4'h0;
         rawPrev <= 4'h0;
      end else begin
         rawPrev <= rawNow;
         istat   <= (istat & ~(wrIstat ? wByte[3:0] : 4'h0)) | (rawNow & ~rawPrev);
         if (wrImask) begin
            imask <= wByte[3:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= ~shownNone | (|(istat & imask));
      end
   end

   // ------------------------------------------------------------
   // read mux and acknowledge
   // ------------------------------------------------------------
   logic [7:0] rdByte;
   always_comb begin
      unique case (idx)
         IDX_DATA:  rdByte = empty ? 8'h00 : mem[rdPtr];
         IDX_IEN:   rdByte = ien;
         IDX_ID:    rdByte = {protoPend, 3'h0, fifo_timeout_status, shownLevel, shownNone};
         IDX_LSR:   rdByte = 8'(lsr);
         IDX_PSRC:  rdByte = {4'h0, protoSrc};
         IDX_COUNT: rdByte = 8'(count);
         IDX_THR:   rdByte = thr;
         IDX_ISTAT: rdByte = {4'h0, istat};
         IDX_IMASK: rdByte = {4'h0, imask};
         default:   rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         if (rd) begin
            wb_dat_o <= {24'h00_0000, rdByte};
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_push_counts: assert property (cpuPush && !pop && !fifoReset |=>
      count == $past(count) + CW'(1) && msgLen == 8'($past(lenCount) + CW'(1)))
      else $error("push did not count");
   a_overflow_drop: assert property (wrData && full && !pop && !fifoReset |=>
      full && msgLen == $past(msgLen))
      else $error("overflow changed state");
   a_pop_counts: assert property (cpuPop && !push && !fifoReset |=>
      count == $past(count) - CW'(1))
      else $error("pop did not count");
   a_underflow_flag: assert property (underflowEvt |=> lsr.underflow && rxBlock [*2])
      else $error("underflow not flagged");
   a_rx_blocked: assert property ((rxBlock || fifo_timeout_status) && rxValid |=>
      count <= $past(count) || $past(wrData))
      else $error("receiver wrote while blocked");
   a_fto_clear: assert property (empty && !timeoutEvt |=> !fifo_timeout_status)
      else $error("timeout status kept while empty");
   a_line_first: assert property (showState == SHOW_LIVE && linePend |=>
      shownLevel == LVL_LINE && !shownNone)
      else $error("line status not highest");
   a_freeze_hold: assert property (showState == SHOW_HELD && !reEnable && stillPend |=>
      $stable(shownLevel) && !shownNone)
      else $error("frozen indication changed");
   a_tx_clear: assert property (clrTx && !txFinished |=> !txDonePend ##1 !txPend)
      else $error("transmit finished not cleared");
   a_irq_out: assert property (!shownNone |=> irq)
      else $error("interrupt output low while pending");
   a_ack_once: assert property (access |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not single cycle");

   c_overflow: cover property (wrData && full);
   c_underflow: cover property (underflowEvt);
   c_freeze_new: cover property (showState == SHOW_HELD && linePend && shownLevel != LVL_LINE);
   c_timeout: cover property (timeoutEvt && !empty ##1 fifo_timeout_status && rxPend);
endmodule

// ===== tb/card_link_model.sv
// card side model: receiver bytes, transmitter pops and line events
`timescale 1ns/1ps
module card_link_model
   import smartcard_irq_pkg::*;
(
   input  wire logic       clk,
   output logic            rxValid,
   output logic      [7:0] rxByte,
   output lineErr_s        lineErr,
   output logic            timeoutEvt,
   output logic            txFinished,
   output logic      [3:0] protoEvt,
   output logic            txPop,
   input  wire logic [7:0] txData,
   input  wire logic       txDataValid
);
   initial begin
      rxValid = 1'b0;
      rxByte = 8'ha5;
      lineErr = '0;
      timeoutEvt = 1'b0;
      txFinished = 1'b0;
      protoEvt = 4'h0;
      txPop = 1'b0;
   end
   task automatic sendByte(input logic [7:0] b);
      @(posedge clk);
      rxValid <= 1'b1;
      rxByte <= b;
      @(posedge clk);
      rxValid <= 1'b0;
      // idle line never shows the last byte
      rxByte <= ~b;
   endtask
   task automatic pulse(input logic [3:0] le, input logic to, input logic tf,
                        input logic [3:0] pe);
      @(posedge clk);
      lineErr <= le;
      timeoutEvt <= to;
      txFinished <= tf;
      protoEvt <= pe;
      @(posedge clk);
      lineErr <= '0;
      timeoutEvt <= 1'b0;
      txFinished <= 1'b0;
      protoEvt <= 4'h0;
   endtask
   task automatic popByte(output logic v, output logic [7:0] d);
      @(posedge clk);
      txPop <= 1'b1;
      @(posedge clk);
      txPop <= 1'b0;
      @(posedge clk);
      v = txDataValid;
      d = txData;
   endtask
endmodule

// ===== tb/smartcard_fifo_irq_registers_tb.sv
// self-checking bench for the smart card fifo and interrupt registers
`timescale 1ns/1ps
module smartcard_fifo_irq_registers_tb;
   import smartcard_irq_pkg::*;
   localparam int DEPTH = 8;
   logic        clk, rst_b, wbCyc, wbStb, wbWe, wbAck, rxValid, timeoutEvt;
   logic        txFinished, txPop, txDataValid, irq;
   logic [5:0]  wbAdr;
   logic [3:0]  wbSel, protoEvt;
   logic [31:0] wbDatI, wbDatO;
   logic [7:0]  rxByte, txData, msgLen;
   lineErr_s    lineErr;
   logic [7:0]  fifoQ[$];
   int          nErrors, testsRun, cycles, seed;

   smartcard_fifo_irq_registers #(.DEPTH(DEPTH)) smartcard_fifo_irq_registers_inst (
      .clk(clk), .rst_b(rst_b), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .rxValid(rxValid), .rxByte(rxByte), .lineErr(lineErr),
      .timeoutEvt(timeoutEvt), .txFinished(txFinished), .protoEvt(protoEvt),
      .txPop(txPop), .txData(txData), .txDataValid(txDataValid), .msgLen(msgLen),
      .irq(irq));
   card_link_model card_link_model_inst (
      .clk(clk), .rxValid(rxValid), .rxByte(rxByte), .lineErr(lineErr),
      .timeoutEvt(timeoutEvt), .txFinished(txFinished), .protoEvt(protoEvt),
      .txPop(txPop), .txData(txData), .txDataValid(txDataValid));

   // ------------------------------------------------------------
   // clock, timeout, checking and bus tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         nErrors++;
         completeRun();
      end
   end
   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0) begin
         $display("No errors found");
      end
      else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
      testsRun++;
      if (got !== exp) begin
         nErrors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chkBit(input string what, input logic exp, input logic got);
      testsRun++;
      if (got !== exp) begin
         nErrors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic wbCycle(input logic [3:0] idx, input logic w, input logic [7:0] d,
                          output logic [7:0] q);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= {idx, 2'b00};
      wbSel <= 4'hf;
      wbDatI <= {24'h000000, d};
      @(posedge clk);
      while (wbAck !== 1'b1) @(posedge clk);
      q = wbDatO[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask
   task automatic wbWr(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wbCycle(idx, 1'b1, d, q);
   endtask
   task automatic rdChk(input string what, input logic [3:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wbCycle(idx, 1'b0, 8'h00, q);
      chkByte(what, exp, q);
   endtask
   task automatic idCheck(input logic [7:0] exp);
      rdChk("ident", IDX_ID, exp);
      repeat (3) @(posedge clk);
      chkBit("irq", ~exp[0], irq);
   endtask
   // live identification value from pending causes
   function automatic logic [7:0] idModel(input int en, ln, rx, tx, pr, fifo_timeout_status);
      logic [7:0] v;
      v = 8'h01;
      if (en[2] && ln != 0) v = 8'h06;
      else if (en[0] && rx != 0) v = 8'h04;
      else if (en[1] && tx != 0) v = 8'h02;
      else if (en[7] && pr != 0) v = 8'h00;
      v[7] = en[7] && pr != 0;
      v[3] = fifo_timeout_status[0];
      return v;
   endfunction

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] b, d;
      logic       v;
      seed = 75891;
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = '0;
      rst_b = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rdChk("enable", IDX_IEN, IEN_RST);
      idCheck(8'h01);
      rdChk("unmapped", 4'h3, 8'h00);
      rdChk("threshold", IDX_THR, THR_RST);
      $display("test reset done");
      for (int i = 0; i < DEPTH + 2; i++) begin
         b = $random(seed);
         wbWr(IDX_DATA, b);
         if (fifoQ.size() < DEPTH) fifoQ.push_back(b);
      end
      chkByte("msgLen", 8'(DEPTH), msgLen);
      rdChk("count", IDX_COUNT, 8'(DEPTH));
      for (int i = 0; i < 3; i++) begin
         card_link_model_inst.popByte(v, d);
         chkBit("txDataValid", 1'b1, v);
         chkByte("txData", fifoQ.pop_front(), d);
      end
      while (fifoQ.size() > 0) rdChk("data", IDX_DATA, fifoQ.pop_front());
      rdChk("count", IDX_COUNT, 8'h00);
      rdChk("empty read", IDX_DATA, 8'h00);
      rdChk("status", IDX_LSR, 8'h08);
      card_link_model_inst.sendByte(8'h5a);
      rdChk("count", IDX_COUNT, 8'h00);
      wbWr(IDX_FCTL, 8'h01);
      chkByte("msgLen", 8'h00, msgLen);
      b = $random(seed);
      card_link_model_inst.sendByte(b);
      rdChk("count", IDX_COUNT, 8'h01);
      rdChk("data", IDX_DATA, b);
      $display("test fifo done");
      wbWr(IDX_IEN, 8'h00);
      card_link_model_inst.pulse(4'h0, 1'b0, 1'b0, 4'h1);
      idCheck(idModel(0, 0, 0, 0, 1, 0));
      wbWr(IDX_IEN, 8'h87);
      idCheck(idModel(8'h87, 0, 0, 0, 1, 0));
      card_link_model_inst.pulse(4'h0, 1'b0, 1'b1, 4'h0);
      idCheck(idModel(8'h87, 0, 0, 0, 1, 0));
      wbWr(IDX_IEN, 8'h87);
      idCheck(idModel(8'h87, 0, 0, 1, 1, 0));
      idCheck(idModel(8'h87, 0, 0, 0, 1, 0));
      card_link_model_inst.pulse(4'h2, 1'b0, 1'b0, 4'h0);
      idCheck(idModel(8'h87, 0, 0, 0, 1, 0));
      wbWr(IDX_IEN, 8'h87);
      idCheck(idModel(8'h87, 1, 0, 0, 1, 0));
      rdChk("status", IDX_LSR, 8'h02);
      idCheck(idModel(8'h87, 0, 0, 0, 1, 0));
      rdChk("source", IDX_PSRC, 8'h01);
      idCheck(8'h01);
      $display("test priority done");
      b = $random(seed);
      card_link_model_inst.sendByte(b);
      card_link_model_inst.pulse(4'h0, 1'b1, 1'b0, 4'h0);
      card_link_model_inst.sendByte(~b);
      rdChk("count", IDX_COUNT, 8'h01);
      idCheck(idModel(8'h87, 0, 1, 0, 0, 1));
      rdChk("data", IDX_DATA, b);
      idCheck(8'h01);
      $display("test timeout done");
      wbWr(IDX_IEN, 8'h00);
      wbWr(IDX_ISTAT, 8'h0f);
      wbWr(IDX_IMASK, 8'h02);
      rdChk("istat", IDX_ISTAT, 8'h00);
      card_link_model_inst.sendByte(8'h3c);
      rdChk("istat", IDX_ISTAT, 8'h02);
      chkBit("irq", 1'b1, irq);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) wbWr(IDX_ISTAT, 8'h02);
         else wbWr(IDX_IMASK, (i == 0) ? 8'h00 : 8'h02);
         repeat (3) @(posedge clk);
         chkBit("irq", i == 1, irq);
      end
      rdChk("istat", IDX_ISTAT, 8'h00);
      rdChk("data", IDX_DATA, 8'h3c);
      $display("test interrupt done");
      completeRun();
   end
endmodule
